// ===== src/ced_core.sv
// Exception detection, priority and state capture with an APB register slave
//
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "ced_defs.svh"
module ced_core
  import ced_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Pipeline, TLB and cache events
  input  wire ced_pipe_s   pipe_in,
  // Bus response channel
  input  wire ced_resp_s   resp_in,
  // Exception taken
  output ced_exc_s         exc_out
);

  ced_state_s            s_reg;
  ced_state_s            s_next;
  ced_kind_e             kind;
  logic                  blocked;
  logic                  iw;
  logic                  dw;
  logic                  f_ade;
  logic                  d_ade;
  logic                  f_miss;
  logic                  f_inv;
  logic                  d_miss;
  logic                  d_inv;
  logic                  ic_take;
  logic                  fetch_bus_error_code;
  logic                  dber;
  logic                  wp_fire;
  logic                  fetch_side;
  logic                  is_st;
  logic [31:0]           fva;
  logic [31:0]           epc_pc;
  logic [31:0]           vec;
  logic [4:0]            code;
  logic [`CED_NVP-1:0]   own_vp;
  logic [`CED_NVP-1:0]   all_vp;
  logic [`CED_NVP-1:0]   dmask;

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `CED_OFF_STATUS) || (a == `CED_OFF_CAUSE) || (a == `CED_OFF_EPC) ||
              (a == `CED_OFF_BADVA) || (a == `CED_OFF_CONTEXT) || (a == `CED_OFF_ENTRYHI) ||
              (a == `CED_OFF_CERR) || (a == `CED_OFF_ERREPC) || (a == `CED_OFF_DEBUG_EXCEPTION_PC) ||
              (a == `CED_OFF_DEBUG) || (a == `CED_OFF_WATCH_MATCH_INFO) || (a == `CED_OFF_TBE);
  endfunction

  function automatic logic [31:0] rd_word(input ced_state_s st, input logic [7:0] a);
    rd_word = 32'h0000_0000;
    if (a == `CED_OFF_STATUS)
    begin
      rd_word[`CED_ST_EXL] = st.exception_level_bit;
      rd_word[`CED_ST_ERL] = st.error_level_bit;
      rd_word[`CED_ST_DM]  = st.dm;
    end
    else if (a == `CED_OFF_CAUSE)
    begin
      rd_word[`CED_CA_BD] = st.bd;
      rd_word[`CED_CA_WP] = st.wp;
      rd_word[6:2]        = st.exccode;
    end
    else if (a == `CED_OFF_EPC)
      rd_word = st.exception_return_pc;
    else if (a == `CED_OFF_BADVA)
      rd_word = st.badva;
    else if (a == `CED_OFF_CONTEXT)
      rd_word = {9'h000, st.ctx_page, 4'h0};
    else if (a == `CED_OFF_ENTRYHI)
      rd_word = {st.ehi_page, 5'h00, st.ehi_address_space_id};
    else if (a == `CED_OFF_CERR)
      rd_word = st.cerr;
    else if (a == `CED_OFF_ERREPC)
      rd_word = st.error_return_pc;
    else if (a == `CED_OFF_DEBUG_EXCEPTION_PC)
      rd_word = st.debug_exception_pc;
    else if (a == `CED_OFF_DEBUG)
    begin
      rd_word[`CED_DBG_DBD] = st.dbd;
      rd_word[`CED_DBG_DIB] = st.instr_break_status;
    end
    else if (a == `CED_OFF_WATCH_MATCH_INFO)
      rd_word = {14'h0000, st.wchan, 13'h0000, st.wirw};
    else if (a == `CED_OFF_TBE)
      rd_word = {{(32-`CED_NTC){1'b0}}, st.thread_bus_error_flag};
  endfunction

  // Event qualification
  always_comb
  begin
    blocked = s_reg.exception_level_bit || s_reg.error_level_bit || s_reg.dm;
    iw      = pipe_in.commit && pipe_in.iwatch;
    dw      = pipe_in.data_valid && pipe_in.dwatch;
    f_ade   = pipe_in.commit && ((pipe_in.pc[1:0] != 2'h0) ||
              (pipe_in.user_mode && pipe_in.pc[31]));
    d_ade   = pipe_in.data_valid && ((pipe_in.data_word && pipe_in.data_addr[1:0] != 2'h0) ||
              (pipe_in.data_half && pipe_in.data_addr[0]) ||
              (pipe_in.user_mode && pipe_in.data_addr[31]));
    f_miss  = pipe_in.commit && pipe_in.imapped && !pipe_in.itlb_hit;
    f_inv   = pipe_in.commit && pipe_in.imapped && pipe_in.itlb_hit && !pipe_in.itlb_valid;
    d_miss  = pipe_in.data_valid && pipe_in.dmapped && !pipe_in.dtlb_hit;
    d_inv   = pipe_in.data_valid && pipe_in.dmapped && pipe_in.dtlb_hit && !pipe_in.dtlb_valid;
    ic_take = pipe_in.commit && pipe_in.ic_perr_exec;
    fetch_bus_error_code     = resp_in.valid && resp_in.code == `CED_RESP_ERR && resp_in.fetch &&
              !resp_in.write;
    dber    = resp_in.valid && resp_in.code == `CED_RESP_ERR && !resp_in.fetch &&
              !resp_in.write;
    wp_fire = s_reg.wp && !blocked;
    own_vp  = {{(`CED_NVP-1){1'b0}}, 1'b1} << pipe_in.vp_id;
    all_vp  = {`CED_NVP{1'b1}};
    dmask   = resp_in.origin_known ? resp_in.vp_mask : all_vp;
    epc_pc  = pipe_in.delay_slot ? pipe_in.pc - `CED_INSN_BYTES : pipe_in.pc;
  end

  // Priority: deferred watch, then fetch side, then data side, imprecise last
  always_comb
  begin
    kind = k_none;
    if (wp_fire)
      kind = k_watch;
    else if (pipe_in.commit && pipe_in.ibreak && !s_reg.dm)
      kind = k_dib;
    else if (iw && !blocked)
      kind = k_watch;
    else if (f_ade)
      kind = k_ade;
    else if (f_miss && !s_reg.exception_level_bit)
      kind = k_tlbr;
    else if (f_miss || f_inv)
      kind = k_tlbi;
    else if (ic_take && !s_reg.error_level_bit)
      kind = k_cerr;
    else if (fetch_bus_error_code)
      kind = k_buse;
    else if (dw && !blocked)
      kind = k_watch;
    else if (d_ade)
      kind = k_ade;
    else if (d_miss && !s_reg.exception_level_bit)
      kind = k_tlbr;
    else if (d_miss || d_inv)
      kind = k_tlbi;
    else if (s_reg.dcerr_pend && !s_reg.error_level_bit)
      kind = k_cerr;
    else if (s_reg.dbe_pend)
      kind = k_buse;
  end

  always_comb
  begin
    s_next     = s_reg;
    fetch_side = wp_fire || (pipe_in.commit && pipe_in.ibreak && !s_reg.dm) ||
                 (iw && !blocked) || f_ade || f_miss || f_inv ||
                 (ic_take && !s_reg.error_level_bit) || fetch_bus_error_code;
    is_st      = !fetch_side && pipe_in.data_store;
    fva        = fetch_side ? pipe_in.pc : pipe_in.data_addr;
    vec        = `CED_GEN_BASE + `CED_OFF_GEN;
    code       = s_reg.exccode;
    s_next.exc.valid   = 1'b0;
    s_next.exc.nonmask = 1'b0;
    s_next.pready      = 1'b0;
    s_next.pslverr     = 1'b0;
    // One wait state: answer registered, then released
    if (psel && penable && !s_reg.pready)
    begin
      s_next.pready  = 1'b1;
      s_next.prdata  = rd_word(s_reg, paddr);
      s_next.pslverr = !addr_ok(paddr);
    end
    // Software writes land first so that hardware events below win
    if (psel && penable && s_reg.pready && pwrite)
    begin
      if (paddr == `CED_OFF_STATUS)
      begin
        s_next.exception_level_bit = pwdata[`CED_ST_EXL];
        s_next.error_level_bit = pwdata[`CED_ST_ERL];
        s_next.dm  = pwdata[`CED_ST_DM];
      end
      else if (paddr == `CED_OFF_CAUSE)
        s_next.wp = pwdata[`CED_CA_WP];
      else if (paddr == `CED_OFF_EPC)
        s_next.exception_return_pc = pwdata;
      else if (paddr == `CED_OFF_ERREPC)
        s_next.error_return_pc = pwdata;
      else if (paddr == `CED_OFF_DEBUG_EXCEPTION_PC)
        s_next.debug_exception_pc = pwdata;
      else if (paddr == `CED_OFF_DEBUG)
      begin
        s_next.instr_break_status = pwdata[`CED_DBG_DIB];
        s_next.dbd = pwdata[`CED_DBG_DBD];
      end
      else if (paddr == `CED_OFF_WATCH_MATCH_INFO)
        s_next.wirw = s_reg.wirw & ~pwdata[2:0];
      else if (paddr == `CED_OFF_TBE)
        s_next.thread_bus_error_flag = s_reg.thread_bus_error_flag & ~pwdata[`CED_NTC-1:0];
    end
    // Cache error information tracks the latest error seen
    if (pipe_in.ic_perr_seen)
      s_next.cerr = pipe_in.ic_perr_info;
    if (pipe_in.dc_err)
      s_next.cerr = pipe_in.dc_err_info;
    if (pipe_in.remote_err)
      s_next.cerr = s_next.cerr | `CED_CERR_EE_MASK;
    if (pipe_in.dc_err || pipe_in.remote_err)
      s_next.dcerr_pend = 1'b1;
    if ((iw || dw) && blocked)
      s_next.wp = 1'b1;
    if (dber)
    begin
      s_next.dbe_pend            = 1'b1;
      s_next.thread_bus_error_flag[resp_in.tc]     = 1'b1;
      s_next.dbe_mask            = s_reg.dbe_pend ? (s_reg.dbe_mask | dmask) : dmask;
    end
    s_next.exc.vp_mask = own_vp;
    case (kind)
      k_dib:
      begin
        s_next.dm    = 1'b1;
        s_next.instr_break_status   = 1'b1;
        s_next.dbd   = pipe_in.delay_slot;
        s_next.debug_exception_pc  = epc_pc;
        vec          = `CED_DEBUG_VEC;
      end
      k_watch:
      begin
        code = `CED_EXC_WATCH;
        if (!wp_fire)
        begin
          s_next.wirw  = (iw && !blocked) ? `CED_WIRW_I :
                         (pipe_in.data_store ? `CED_WIRW_W : `CED_WIRW_R);
          s_next.wchan = (iw && !blocked) ? pipe_in.iwatch_chan : pipe_in.dwatch_chan;
        end
      end
      k_ade:
      begin
        code         = is_st ? `CED_EXC_ADDR_ERR_STORE_CODE : `CED_EXC_ADDR_ERR_LOAD_CODE;
        s_next.badva = fva;
      end
      k_tlbr, k_tlbi:
      begin
        code            = is_st ? `CED_EXC_TLB_STORE_MISS_CODE : `CED_EXC_TLB_LOAD_MISS_CODE;
        s_next.badva    = fva;
        s_next.ctx_page = fva[`CED_VPN_MSB:`CED_VPN_LSB];
        s_next.ehi_page = fva[`CED_VPN_MSB:`CED_VPN_LSB];
        s_next.ehi_address_space_id = pipe_in.address_space_id;
        if (kind == k_tlbr && !s_reg.exception_level_bit)
          vec = `CED_GEN_BASE + `CED_OFF_REFILL;
      end
      k_cerr:
      begin
        s_next.error_level_bit         = 1'b1;
        s_next.error_return_pc    = epc_pc;
        s_next.exc.nonmask = 1'b1;
        vec                = `CED_UNC_BASE + `CED_OFF_CACHE_ERROR_INFO;
        if (fetch_side)
          s_next.exc.vp_mask = own_vp;
        else
        begin
          s_next.exc.vp_mask = all_vp;
          s_next.dcerr_pend  = pipe_in.dc_err || pipe_in.remote_err;
        end
      end
      k_buse:
      begin
        if (fetch_side)
          code = `CED_EXC_IBE;
        else
        begin
          code               = `CED_EXC_DBE;
          s_next.exc.vp_mask = s_reg.dbe_mask;
          s_next.dbe_pend    = dber;
          s_next.dbe_mask    = dmask;
        end
      end
      default:
      begin
        vec = `CED_GEN_BASE + `CED_OFF_GEN;
      end
    endcase
    // Architectural codes and EXCEPTION_RETURN_PC only for the general class
    if (kind != k_none && kind != k_dib && kind != k_cerr)
    begin
      s_next.exception_level_bit     = 1'b1;
      s_next.exccode = code;
      if (!s_reg.exception_level_bit)
      begin
        s_next.exception_return_pc = epc_pc;
        s_next.bd  = pipe_in.delay_slot;
      end
    end
    s_next.exc.valid  = (kind != k_none);
    s_next.exc.code   = code;
    s_next.exc.vector = vec;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign prdata  = s_reg.prdata;
  assign pready  = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign exc_out = s_reg.exc;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_apb_access;
    psel && penable && !s_reg.pready;
  endsequence
  sequence s_apb_release;
    s_reg.pready ##1 !s_reg.pready;
  endsequence
  sequence s_wp_fire;
    s_reg.wp && !blocked;
  endsequence

  a_apb_one_wait: assert property (s_apb_access |=> s_apb_release)
    else $error("APB answer not one wait state");
  a_dib_entry: assert property (kind == k_dib |=>
      s_reg.dm && s_reg.instr_break_status && exc_out.valid && exc_out.vector == `CED_DEBUG_VEC &&
      s_reg.debug_exception_pc == $past(epc_pc))
    else $error("Instruction break entry wrong");
  a_watch_now: assert property (iw && !blocked && !s_reg.wp &&
      !(pipe_in.ibreak && !s_reg.dm) |=> exc_out.valid &&
      exc_out.code == `CED_EXC_WATCH && s_reg.exception_level_bit)
    else $error("Unblocked watch not taken");
  a_watch_defer: assert property ((iw || dw) && blocked |=>
      s_reg.wp && !(exc_out.valid && exc_out.code == `CED_EXC_WATCH))
    else $error("Blocked watch not deferred");
  a_wp_source: assert property (s_wp_fire |=> exc_out.valid &&
      exc_out.code == `CED_EXC_WATCH && exc_out.vector == `CED_GEN_BASE + `CED_OFF_GEN)
    else $error("Pending watch did not fire");
  a_watch_order: assert property (iw && dw && !blocked && !s_reg.wp &&
      !(pipe_in.ibreak && !s_reg.dm) |=> s_reg.wirw == `CED_WIRW_I)
    else $error("Data watch beat fetch watch");
  a_fetch_ade: assert property (kind == k_ade && f_ade && !s_reg.exception_level_bit &&
      !pipe_in.delay_slot |=> s_reg.exception_return_pc == $past(pipe_in.pc) &&
      s_reg.badva == $past(pipe_in.pc) && s_reg.exccode == `CED_EXC_ADDR_ERR_LOAD_CODE)
    else $error("Fetch address error state wrong");
  a_refill_vec: assert property (kind == k_tlbr |=>
      exc_out.vector == `CED_GEN_BASE + `CED_OFF_REFILL &&
      s_reg.ctx_page == $past(fva[`CED_VPN_MSB:`CED_VPN_LSB]))
    else $error("Refill vector or page wrong");
  a_tlbi_vec: assert property (kind == k_tlbi |=>
      exc_out.vector == `CED_GEN_BASE + `CED_OFF_GEN)
    else $error("TLB invalid vector wrong");
  a_cerr_entry: assert property (kind == k_cerr |=> exc_out.nonmask &&
      s_reg.error_level_bit && exc_out.vector == `CED_UNC_BASE + `CED_OFF_CACHE_ERROR_INFO)
    else $error("Cache error entry wrong");
  a_remote_flag: assert property (pipe_in.remote_err |=>
      (s_reg.cerr & `CED_CERR_EE_MASK) != 32'h0000_0000)
    else $error("Remote flag not set");
  a_no_write_be: assert property (resp_in.valid && resp_in.write &&
      !s_reg.dbe_pend |=> !s_reg.dbe_pend)
    else $error("Bus error raised for a write");
  a_tbe_set: assert property (dber |=> s_reg.thread_bus_error_flag[$past(resp_in.tc)])
    else $error("Thread bus error flag not set");
  a_cerr_share: assert property (kind == k_cerr && !fetch_side |=>
      exc_out.vp_mask == {`CED_NVP{1'b1}})
    else $error("Data cache error not shared");
  a_dbe_route: assert property (dber && !s_reg.dbe_pend |=>
      s_reg.dbe_mask == ($past(resp_in.origin_known) ? $past(resp_in.vp_mask) :
      {`CED_NVP{1'b1}}))
    else $error("Bus error processor mask wrong");

endmodule

// ===== src/ced_defs.svh
// Constants for the exception detection block: offsets, fields, codes, vectors
//
// What this block does
// - Instruction breakpoint match raises debug exception
// - Watch taken now when all three clear
// - Watch while blocked sets pending flag
// - Pending flag itself raises watch when unblocked
// - Fetch watch match beats data match
// - Watch reports code, match type, general vector
// - Misaligned or user-kernel reference raises address error
// - Misaligned fetch: return PC equals faulting address
// - Address error load/store code, general vector
// - TLB miss with level clear raises refill
// - TLB faults capture page, address space id
// - Refill vector by exception level at fault
// - Miss at level set, or invalid entry
// - Cache error: save state, uncached vector
// - Instruction parity taken only when executing
// - Latest instruction parity error overwrites info
// - Data integrity error hits every sharing processor
// - Remote core cache error sets remote flag
// - Bus error on fetch/read only, never write
// - Fetch bus error precise and first
// - Data bus error: thread flag, processor mask
`ifndef CED_DEFS_SVH
`define CED_DEFS_SVH
`define CED_NVP          2
`define CED_VPW          1
`define CED_NTC          4
`define CED_TCW          2
`define CED_OFF_STATUS   8'h00
`define CED_OFF_CAUSE    8'h04
`define CED_OFF_EPC      8'h08
`define CED_OFF_BADVA    8'h0C
`define CED_OFF_CONTEXT  8'h10
`define CED_OFF_ENTRYHI  8'h14
`define CED_OFF_CERR     8'h18
`define CED_OFF_ERREPC   8'h1C
`define CED_OFF_DEBUG_EXCEPTION_PC     8'h20
`define CED_OFF_DEBUG    8'h24
`define CED_OFF_WATCH_MATCH_INFO  8'h28
`define CED_OFF_TBE      8'h2C
`define CED_ST_EXL       0
`define CED_ST_ERL       1
`define CED_ST_DM        2
`define CED_CA_WP        22
`define CED_CA_BD        31
`define CED_DBG_DIB      4
`define CED_DBG_DBD      31
`define CED_CTX_SHIFT    4
`define CED_VPN_MSB      31
`define CED_VPN_LSB      13
`define CED_CERR_EE_MASK 32'h0800_0000
`define CED_WIRW_I       3'h4
`define CED_WIRW_R       3'h2
`define CED_WIRW_W       3'h1
`define CED_RESP_ERR     2'h3
`define CED_EXC_TLB_LOAD_MISS_CODE     5'h02
`define CED_EXC_TLB_STORE_MISS_CODE     5'h03
`define CED_EXC_ADDR_ERR_LOAD_CODE     5'h04
`define CED_EXC_ADDR_ERR_STORE_CODE     5'h05
`define CED_EXC_IBE      5'h06
`define CED_EXC_DBE      5'h07
`define CED_EXC_WATCH    5'h17
`define CED_GEN_BASE     32'h8000_0000
`define CED_OFF_GEN      32'h0000_0180
`define CED_OFF_REFILL   32'h0000_0000
`define CED_UNC_BASE     32'hA000_0000
`define CED_OFF_CACHE_ERROR_INFO 32'h0000_0100
`define CED_DEBUG_VEC    32'hBFC0_0480
`define CED_INSN_BYTES   32'h0000_0004
`endif

// ===== src/ced_pkg.sv
// Types for the exception detection block
package ced_pkg;
`include "ced_defs.svh"
  typedef enum logic [7:0] {
    k_none  = 8'h01, k_dib  = 8'h02, k_watch = 8'h04, k_ade  = 8'h08,
    k_tlbr  = 8'h10, k_tlbi = 8'h20, k_cerr  = 8'h40, k_buse = 8'h80
  } ced_kind_e;
  typedef struct packed {
    logic commit; logic [31:0] pc; logic delay_slot; logic user_mode;
    logic [`CED_VPW-1:0] vp_id; logic ibreak; logic iwatch; logic [1:0] iwatch_chan;
    logic imapped; logic itlb_hit; logic itlb_valid;
    logic ic_perr_seen; logic ic_perr_exec; logic [31:0] ic_perr_info;
    logic data_valid; logic data_store; logic data_half; logic data_word;
    logic [31:0] data_addr; logic dwatch; logic [1:0] dwatch_chan;
    logic dmapped; logic dtlb_hit; logic dtlb_valid; logic [7:0] address_space_id;
    logic dc_err; logic remote_err; logic [31:0] dc_err_info;
  } ced_pipe_s;
  typedef struct packed {
    logic valid; logic [1:0] code; logic fetch; logic write;
    logic [`CED_TCW-1:0] tc; logic [`CED_NVP-1:0] vp_mask; logic origin_known;
  } ced_resp_s;
  typedef struct packed {
    logic valid; logic [4:0] code; logic [31:0] vector;
    logic [`CED_NVP-1:0] vp_mask; logic nonmask;
  } ced_exc_s;
  typedef struct packed {
    logic exception_level_bit; logic error_level_bit; logic dm; logic wp; logic bd; logic instr_break_status; logic dbd;
    logic [4:0] exccode; logic [31:0] exception_return_pc; logic [31:0] badva; logic [31:0] cerr;
    logic [31:0] error_return_pc; logic [31:0] debug_exception_pc; logic [18:0] ctx_page;
    logic [18:0] ehi_page; logic [7:0] ehi_address_space_id; logic [2:0] wirw; logic [1:0] wchan;
    logic [`CED_NTC-1:0] thread_bus_error_flag; logic dbe_pend; logic [`CED_NVP-1:0] dbe_mask;
    logic dcerr_pend; logic pready; logic pslverr; logic [31:0] prdata; ced_exc_s exc;
  } ced_state_s;
endpackage

// ===== sim/ced_fabric.sv
// Bus fabric model returning one response per command after a chosen wait
`timescale 1ns/100ps
module ced_fabric
  import ced_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Command from the bench
  input  wire logic       go,
  input  wire ced_resp_s  cmd,
  input  wire logic [3:0] dly,
  // Response channel
  output ced_resp_s       resp
);
  ced_resp_s  hold;
  logic [4:0] cnt;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt  <= '0;
      hold <= '0;
      resp <= '0;
    end
    else if (go)
    begin
      hold       <= cmd;
      cnt        <= {1'h0, dly} + 5'h01;
      resp.valid <= 1'h0;
    end
    else
    begin
      // Idle fields keep changing so stale values cannot pass
      resp <= (cnt == 5'h01) ? hold : ced_resp_s'({1'h0, ~resp[8:0]});
      cnt  <= (cnt != 5'h00) ? cnt - 5'h01 : cnt;
    end
endmodule

// ===== sim/cpu_exception_detection_test.sv
// Self-checking bench for the exception detection block
`timescale 1ns/100ps
`include "ced_defs.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR %0t got %h want %h", $time, a, b); end end
module cpu_exception_detection_test
  import ced_pkg::*;
;
  localparam logic [31:0] GV = `CED_GEN_BASE + `CED_OFF_GEN;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, go, se;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, a;
  logic [36:0] e;
  logic [3:0]  dly;
  ced_pipe_s   pipe, p;
  ced_resp_s   resp_in, cmd;
  ced_exc_s    exc_out;
  logic [36:0] expq[$];
  int          n_mismatch, compares;
  ced_core ced_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pipe_in(pipe), .resp_in(resp_in), .exc_out(exc_out));
  ced_fabric ced_fabric_inst (.pclk(pclk), .presetn(presetn), .go(go), .cmd(cmd),
    .dly(dly), .resp(resp_in));
  initial
  begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  // Falling edge sees the registered exception settled
  always @(negedge pclk)
    if (exc_out.valid === 1'h1)
    begin
      e = expq.size() ? expq.pop_front() : 37'h1F_0000_0000;
      `CHK(exc_out.vector, e[31:0])
      `CHK(exc_out.nonmask, e[31:0] == (`CED_UNC_BASE + `CED_OFF_CACHE_ERROR_INFO))
      if (e[36:32] != 5'h1F)
        `CHK(exc_out.code, e[36:32])
    end
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // Only the watchdog ends a wait that never sees pready
    do
      @(posedge pclk);
    while (pready !== 1'h1);
    q  = prdata;
    se = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] want);
    apb(1'h0, ad, 32'h0);
    `CHK(q, want)
  endtask
  task automatic ev(input ced_pipe_s x);
    pipe <= x;
    @(posedge pclk);
    pipe <= '0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic expx(input logic [4:0] c, input logic [31:0] v);
    expq.push_back({c, v});
  endtask
  task automatic summarize();
    if (expq.size() != 0)
      n_mismatch++;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_mismatch++;
    summarize();
  end
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, go, dly} = '0;
    pipe = '0;
    cmd = '0;
    n_mismatch = 0;
    compares = 0;
    void'($urandom(5));
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(`CED_OFF_STATUS, 32'h0);
    apb(1'h0, 8'h40, 32'h0);
    `CHK(se, 1'h1)
    $display("test reset done");
    a = $urandom & 32'h7FFF_FFFC | 32'h2;
    p = '0;
    p.commit = 1'h1;
    p.pc = a;
    expx(`CED_EXC_ADDR_ERR_LOAD_CODE, GV);
    ev(p);
    rd(`CED_OFF_EPC, a);
    rd(`CED_OFF_BADVA, a);
    apb(1'h1, `CED_OFF_STATUS, 32'h0);
    p.pc = 32'h0;
    {p.data_valid, p.data_store, p.data_half} = 3'h7;
    p.data_addr = a | 32'h1;
    expx(`CED_EXC_ADDR_ERR_STORE_CODE, GV);
    ev(p);
    apb(1'h1, `CED_OFF_STATUS, 32'h0);
    {p.data_store, p.data_half, p.data_word, p.user_mode} = 4'h3;
    p.data_addr = 32'h8000_0000;
    expx(`CED_EXC_ADDR_ERR_LOAD_CODE, GV);
    ev(p);
    apb(1'h1, `CED_OFF_STATUS, 32'h0);
    $display("test address error done");
    p = '0;
    {p.commit, p.data_valid, p.data_word, p.dmapped} = 4'hF;
    p.data_addr = $urandom & 32'h7FFF_FFFC;
    p.address_space_id = 8'($urandom);
    expx(`CED_EXC_TLB_LOAD_MISS_CODE, `CED_GEN_BASE + `CED_OFF_REFILL);
    ev(p);
    rd(`CED_OFF_CONTEXT, {9'h0, p.data_addr[31:13], 4'h0});
    rd(`CED_OFF_ENTRYHI, {p.data_addr[31:13], 5'h0, p.address_space_id});
    p.data_store = 1'h1;
    expx(`CED_EXC_TLB_STORE_MISS_CODE, GV);
    ev(p);
    apb(1'h1, `CED_OFF_STATUS, 32'h0);
    p.dtlb_hit = 1'h1;
    expx(`CED_EXC_TLB_STORE_MISS_CODE, GV);
    ev(p);
    apb(1'h1, `CED_OFF_STATUS, 32'h0);
    $display("test tlb done");
    p = '0;
    {p.commit, p.iwatch, p.dwatch, p.data_valid, p.data_word} = 5'h1F;
    p.iwatch_chan = 2'h1;
    p.dwatch_chan = 2'h2;
    expx(`CED_EXC_WATCH, GV);
    ev(p);
    rd(`CED_OFF_WATCH_MATCH_INFO, 32'h0001_0004);
    ev(p);
    rd(`CED_OFF_CAUSE, 32'h0040_005C);
    expx(`CED_EXC_WATCH, GV);
    apb(1'h1, `CED_OFF_STATUS, 32'h0);
    apb(1'h1, `CED_OFF_CAUSE, 32'h0);
    apb(1'h1, `CED_OFF_STATUS, 32'h0);
    $display("test watch done");
    p = '0;
    {p.commit, p.ibreak, p.delay_slot} = 3'h7;
    p.pc = a & 32'hFFFF_FFFC;
    expx(5'h1F, `CED_DEBUG_VEC);
    ev(p);
    rd(`CED_OFF_DEBUG_EXCEPTION_PC, p.pc - 32'h0000_0004);
    rd(`CED_OFF_DEBUG, 32'h8000_0010);
    apb(1'h1, `CED_OFF_STATUS, 32'h0);
    $display("test breakpoint done");
    for (int i = 0; i < 3; i++)
    begin
      cmd <= {1'h1, `CED_RESP_ERR, 1'(i == 0), 1'(i == 1), 2'h2, 2'h1, 1'h1};
      dly <= 4'($urandom % 4);
      go  <= 1'h1;
      if (i != 1)
        expx(i == 0 ? `CED_EXC_IBE : `CED_EXC_DBE, GV);
      @(posedge pclk);
      go  <= 1'h0;
      repeat (8) @(posedge pclk);
      apb(1'h1, `CED_OFF_STATUS, 32'h0);
    end
    rd(`CED_OFF_TBE, 32'h0000_0004);
    $display("test bus error done");
    p = '0;
    p.remote_err = 1'h1;
    expx(5'h1F, `CED_UNC_BASE + `CED_OFF_CACHE_ERROR_INFO);
    ev(p);
    apb(1'h0, `CED_OFF_CERR, 32'h0);
    `CHK(q & `CED_CERR_EE_MASK, `CED_CERR_EE_MASK)
    apb(1'h1, `CED_OFF_STATUS, 32'h0);
    p = '0;
    p.ic_perr_seen = 1'h1;
    p.ic_perr_info = 32'h0000_0111;
    ev(p);
    {p.commit, p.ic_perr_exec} = 2'h3;
    p.ic_perr_info = 32'h0000_0222;
    expx(5'h1F, `CED_UNC_BASE + `CED_OFF_CACHE_ERROR_INFO);
    ev(p);
    rd(`CED_OFF_CERR, 32'h0000_0222);
    $display("test cache error done");
    summarize();
  end
endmodule
